// ==== design/aix_consts.vh ====
// Constants for the analog input result word block
`ifndef AIX_CONSTS_VH
`define AIX_CONSTS_VH

// Register indices; byte address is four times the index
`define AIX_IDX_CH0_RESULT 6'h00
`define AIX_IDX_CH1_RESULT 6'h01
`define AIX_IDX_CH2_RESULT 6'h02
`define AIX_IDX_CH3_RESULT 6'h03
`define AIX_IDX_FAULT_SUMMARY 6'h04
`define AIX_IDX_RANGE_FLAGS 6'h05
`define AIX_IDX_RESERVED_WORD 6'h06
`define AIX_IDX_CH0_CONFIG 6'h08
`define AIX_IDX_CH3_CONFIG 6'h0b
`define AIX_IDX_CONTROL 6'h0c
`define AIX_IDX_STATUS 6'h0d
`define AIX_IDX_IRQ_STATUS 6'h0e
`define AIX_IDX_IRQ_MASK 6'h0f

// Channel configuration word fields
`define AIX_CFG_FMT_MSB 14
`define AIX_CFG_FMT_LSB 12
`define AIX_CFG_RNG_MSB 11
`define AIX_CFG_RNG_LSB 8
`define AIX_CFG_RESET 16'h0000

// Data format and type/range codes
`define AIX_FMT_RAW 3'h0
`define AIX_FMT_PID 3'h2
`define AIX_RNG_VOLT 4'h0
`define AIX_RNG_CURR 4'h3

// Full-range limits in converter counts, two's complement
`define AIX_VOLT_LO 16'hc000
`define AIX_VOLT_HI 16'h3fff
`define AIX_CURR_LO 16'h4000
`define AIX_CURR_HI 16'h7fff

// Control, status and interrupt bit positions
`define AIX_CTRL_RUN 0
`define AIX_STAT_RUNNING 0
`define AIX_STAT_CFG_ERR 1
`define AIX_STAT_HW_ERR 2
`define AIX_STAT_CH_BAD_LSB 4
`define AIX_IRQ_CFG_ERR 0
`define AIX_IRQ_HW_ERR 1
`define AIX_IRQ_CH_LSB 2
`define AIX_IRQ_WIDTH 6

`endif

// ==== design/aix_chan_fmt.v ====
// One channel: range check, clamp and result word formatting
`timescale 1ns/1ps
`default_nettype none
`include "aix_consts.vh"

module aix_chan_fmt (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // Control
    input wire running,
    input wire [2:0] fmt,
    input wire [3:0] rng,
    // Converter sample
    input wire [15:0] sample,
    input wire sample_valid,
    // Result
    output reg [15:0] result_reg,
    output reg over_range_flag,
    output reg under_range_flag
);

    reg signed [15:0] lo;
    reg signed [15:0] hi;
    reg signed [15:0] clamped;
    reg [16:0] offset;
    reg [15:0] result_next;
    wire signed [15:0] s;
    wire is_over;
    wire is_under;

    assign s = sample;

    always @* begin
        if (rng == `AIX_RNG_CURR) begin
            lo = `AIX_CURR_LO;
            hi = `AIX_CURR_HI;
        end else begin
            lo = `AIX_VOLT_LO;
            hi = `AIX_VOLT_HI;
        end
    end

    assign is_over = s > hi;
    assign is_under = s < lo;

    // Out of range keeps converting at the full-range limit
    always @* begin
        if (is_over) begin
            clamped = hi;
        end else if (is_under) begin
            clamped = lo;
        end else begin
            clamped = s;
        end
        offset = {clamped[15], clamped} - {lo[15], lo};
        if (fmt == `AIX_FMT_PID) begin
            // PID scaling spans 0 to 16383; sign stays clear
            if (rng == `AIX_RNG_CURR) begin
                result_next = offset[15:0];
            end else begin
                result_next = offset[16:1];
            end
        end else begin
            result_next = clamped;
        end
    end

    // Flags follow each sample, so they clear once the input is back
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 16'h0000;
            over_range_flag <= 1'b0;
            under_range_flag <= 1'b0;
        end else if (ce) begin
            if (!running) begin
                over_range_flag <= 1'b0;
                under_range_flag <= 1'b0;
            end else if (sample_valid) begin
                result_reg <= result_next;
                over_range_flag <= is_over;
                under_range_flag <= is_under;
            end
        end
    end

endmodule
`default_nettype wire

// ==== design/aix_result_words.v ====
// Analog input result words with APB register access
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "aix_consts.vh"

module aix_result_words #(
    parameter NCH = 4
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Converter front end, channel n in bits 16n+15 to 16n
    input wire [16*NCH-1:0] ch_sample,
    input wire [NCH-1:0] ch_sample_valid,
    // Module hardware error from outside logic
    input wire hw_error,
    // Run state and interrupt
    output wire running,
    output wire irq
);

    // Host side configuration, written at any time
    reg [15:0] cfg_reg [0:NCH-1];
    // Configuration in effect, captured on entry into run
    reg [2:0] act_fmt_reg [0:NCH-1];
    reg [3:0] act_rng_reg [0:NCH-1];
    reg run_req_reg;
    reg running_reg;
    reg cfg_err_reg;
    reg [NCH-1:0] ch_bad_reg;
    reg hw_meta_reg;
    reg hw_sync_reg;
    reg hw_prev_reg;
    reg [`AIX_IRQ_WIDTH-1:0] irq_stat_reg;
    reg [`AIX_IRQ_WIDTH-1:0] irq_mask_reg;
    reg [`AIX_IRQ_WIDTH-1:0] irq_event;
    reg [NCH-1:0] fault_prev_reg;
    reg err_reg;
    reg [31:0] rd_next;
    reg err_next;
    reg [NCH-1:0] cfg_bad;

    wire [16*NCH-1:0] results;
    wire [NCH-1:0] over;
    wire [NCH-1:0] under;
    wire [NCH-1:0] ch_fault;
    wire [15:0] fault_word;
    wire [15:0] flag_word;
    wire [5:0] idx;
    wire setup;
    wire wr_access;
    wire go_run;

    integer i;
    genvar g;

    assign idx = paddr[7:2];
    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite & ce;
    // Zero wait: read data was captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_reg;

    // Format and range code checks
    always @* begin
        for (i = 0; i < NCH; i = i + 1) begin
            cfg_bad[i] = 1'b0;
            if (cfg_reg[i][`AIX_CFG_FMT_MSB:`AIX_CFG_FMT_LSB] != `AIX_FMT_RAW
                && cfg_reg[i][`AIX_CFG_FMT_MSB:`AIX_CFG_FMT_LSB]
                != `AIX_FMT_PID) begin
                cfg_bad[i] = 1'b1;
            end
            if (cfg_reg[i][`AIX_CFG_RNG_MSB:`AIX_CFG_RNG_LSB] != `AIX_RNG_VOLT
                && cfg_reg[i][`AIX_CFG_RNG_MSB:`AIX_CFG_RNG_LSB]
                != `AIX_RNG_CURR) begin
                cfg_bad[i] = 1'b1;
            end
        end
    end

    assign go_run = run_req_reg & ~running_reg & ~cfg_err_reg;

    // Hardware error crosses in from another part of the module
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_meta_reg <= 1'b0;
            hw_sync_reg <= 1'b0;
            hw_prev_reg <= 1'b0;
        end else if (ce) begin
            hw_meta_reg <= hw_error;
            hw_sync_reg <= hw_meta_reg;
            hw_prev_reg <= hw_sync_reg;
        end
    end

    // Configuration and control writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < NCH; i = i + 1) begin
                cfg_reg[i] <= `AIX_CFG_RESET;
            end
            run_req_reg <= 1'b0;
            irq_mask_reg <= {`AIX_IRQ_WIDTH{1'b0}};
        end else if (wr_access) begin
            if (idx >= `AIX_IDX_CH0_CONFIG && idx <= `AIX_IDX_CH3_CONFIG) begin
                cfg_reg[idx[1:0]] <= pwdata[15:0];
            end else if (idx == `AIX_IDX_CONTROL) begin
                run_req_reg <= pwdata[`AIX_CTRL_RUN];
            end else if (idx == `AIX_IDX_IRQ_MASK) begin
                irq_mask_reg <= pwdata[`AIX_IRQ_WIDTH-1:0];
            end
        end
    end

    // Run state; a rejected configuration keeps the module out of run
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_reg <= 1'b0;
            cfg_err_reg <= 1'b0;
            ch_bad_reg <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                act_fmt_reg[i] <= `AIX_FMT_RAW;
                act_rng_reg[i] <= `AIX_RNG_VOLT;
            end
        end else if (ce) begin
            if (!run_req_reg) begin
                running_reg <= 1'b0;
                cfg_err_reg <= 1'b0;
            end else if (go_run) begin
                ch_bad_reg <= cfg_bad;
                if (|cfg_bad) begin
                    cfg_err_reg <= 1'b1;
                end else begin
                    running_reg <= 1'b1;
                    for (i = 0; i < NCH; i = i + 1) begin
                        act_fmt_reg[i] <=
                            cfg_reg[i][`AIX_CFG_FMT_MSB:`AIX_CFG_FMT_LSB];
                        act_rng_reg[i] <=
                            cfg_reg[i][`AIX_CFG_RNG_MSB:`AIX_CFG_RNG_LSB];
                    end
                end
            end
        end
    end

    assign running = running_reg;

    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            aix_chan_fmt u_fmt (
                .pclk(pclk),
                .presetn(presetn),
                .ce(ce),
                .running(running_reg),
                .fmt(act_fmt_reg[g]),
                .rng(act_rng_reg[g]),
                .sample(ch_sample[16*g+15:16*g]),
                .sample_valid(ch_sample_valid[g]),
                .result_reg(results[16*g+15:16*g]),
                .over_range_flag(over[g]),
                .under_range_flag(under[g])
            );
            assign ch_fault[g] = over[g] | under[g] | hw_sync_reg;
            assign flag_word[15-2*g] = under[g];
            assign flag_word[14-2*g] = over[g];
        end
    endgenerate

    assign fault_word = {{(16-NCH){1'b0}}, ch_fault};
    assign flag_word[7:0] = 8'h00;

    // Interrupt events: config reject, hardware error, new channel fault
    always @* begin
        irq_event = {`AIX_IRQ_WIDTH{1'b0}};
        irq_event[`AIX_IRQ_CFG_ERR] = go_run & (|cfg_bad);
        irq_event[`AIX_IRQ_HW_ERR] = hw_sync_reg & ~hw_prev_reg;
        for (i = 0; i < NCH; i = i + 1) begin
            irq_event[`AIX_IRQ_CH_LSB+i] = (over[i] | under[i])
                & ~fault_prev_reg[i];
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= {`AIX_IRQ_WIDTH{1'b0}};
            fault_prev_reg <= {NCH{1'b0}};
        end else if (ce) begin
            fault_prev_reg <= over | under;
            if (psel & penable & pwrite & (idx == `AIX_IDX_IRQ_STATUS)) begin
                irq_stat_reg <= (irq_stat_reg
                    & ~pwdata[`AIX_IRQ_WIDTH-1:0]) | irq_event;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_event;
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read decode
    always @* begin
        rd_next = 32'h00000000;
        err_next = 1'b0;
        if (idx <= `AIX_IDX_CH3_RESULT) begin
            rd_next[15:0] = results[16*idx[1:0] +: 16];
        end else if (idx == `AIX_IDX_FAULT_SUMMARY) begin
            rd_next[15:0] = fault_word;
        end else if (idx == `AIX_IDX_RANGE_FLAGS) begin
            rd_next[15:0] = flag_word;
        end else if (idx == `AIX_IDX_RESERVED_WORD) begin
            rd_next = 32'h00000000;
        end else if (idx >= `AIX_IDX_CH0_CONFIG
            && idx <= `AIX_IDX_CH3_CONFIG) begin
            rd_next[15:0] = cfg_reg[idx[1:0]];
        end else if (idx == `AIX_IDX_CONTROL) begin
            rd_next[`AIX_CTRL_RUN] = run_req_reg;
        end else if (idx == `AIX_IDX_STATUS) begin
            rd_next[`AIX_STAT_RUNNING] = running_reg;
            rd_next[`AIX_STAT_CFG_ERR] = cfg_err_reg;
            rd_next[`AIX_STAT_HW_ERR] = hw_sync_reg;
            rd_next[`AIX_STAT_CH_BAD_LSB+NCH-1:`AIX_STAT_CH_BAD_LSB] =
                ch_bad_reg;
        end else if (idx == `AIX_IDX_IRQ_STATUS) begin
            rd_next[`AIX_IRQ_WIDTH-1:0] = irq_stat_reg;
        end else if (idx == `AIX_IDX_IRQ_MASK) begin
            rd_next[`AIX_IRQ_WIDTH-1:0] = irq_mask_reg;
        end else begin
            err_next = 1'b1;
        end
    end

    // Capture in setup so prdata comes from a flop with no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            err_reg <= 1'b0;
        end else if (ce & setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_next;
            err_reg <= err_next;
        end
    end

endmodule
`default_nettype wire

// ==== sim/aix_result_words_chk.sv ====
// Assertion checker for the analog input result word block
`timescale 1ns/1ps
`default_nettype none
module aix_result_words_chk #(
    parameter NCH = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Converter, run state, interrupt
    input wire logic [16*NCH-1:0] ch_sample,
    input wire logic [NCH-1:0] ch_sample_valid,
    input wire logic hw_error,
    input wire logic running,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [5:0] idx = paddr[7:2];
    wire logic setup = psel && !penable && ce;
    wire logic access = psel && penable;
    wire logic bad_idx = idx == 6'h07 || idx > 6'h0f;
    wire logic run_wr = access && pwrite && idx == 6'h0c && pwdata[0];
    a_ready_const: assert property (pready)
        else $error("ready dropped");
    a_err_unmapped: assert property (access && bad_idx |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (access && !bad_idx |-> !pslverr)
        else $error("mapped access refused");
    a_upper_zero: assert property (setup |=> prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_reserved_word: assert property (setup && idx == 6 |=> prdata == 0)
        else $error("reserved word not zero");
    a_fault_rsvd: assert property (setup && idx == 4 |=> prdata[15:4] == 0)
        else $error("fault word reserved bits set");
    a_flags_rsvd: assert property (setup && idx == 5 |=> prdata[7:0] == 0)
        else $error("flag word reserved bits set");
    a_idle_flags: assert property (setup && idx == 5 && !running
        && !$past(running) |=> prdata[15:8] == 0)
        else $error("range flags set while stopped");
    a_run_cause: assert property ($rose(running)
        |-> $past(run_wr) || $past(run_wr, 2))
        else $error("run entered without a run write");
    cover property (run_wr ##[1:2] running);
    cover property (access && bad_idx);
    cover property (setup && idx == 5 ##1 prdata[15:8] != 0);
    cover property ($rose(irq));
endmodule
bind aix_result_words aix_result_words_chk #(.NCH(NCH)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ch_sample(ch_sample), .ch_sample_valid(ch_sample_valid),
    .hw_error(hw_error), .running(running), .irq(irq)
);
`default_nettype wire

// ==== sim/aix_host_model.sv ====
// Host controller model: APB master reaching the module's words
`timescale 1ns/1ps
`default_nettype none
module aix_host_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // Built-in I/O is slot 0, so this module sits at slot 1
    localparam int SLOT = 1;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Ends with an idle cycle so psel is never driven twice in one step
    task automatic xfer(input logic wr, input logic [5:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err,
        output logic ok);
        int n;
        ok = 1'b0;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        while (!ok && n < 20) begin
            @(posedge pclk);
            n++;
            ok = pready === 1'b1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the analog input result word block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
    miscompares++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic [63:0] ch_sample = 64'h0;
    logic [3:0] ch_sample_valid = 4'h0;
    logic hw_error = 1'b0;
    wire logic psel, penable, pwrite, pready, pslverr, running, irq;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    logic [31:0] rdat;
    logic err;
    int miscompares = 0;
    int check_count = 0;
    // Channel, sample, result, range flags, fault summary
    logic [79:0] vec [9] = '{80'h0000_f000_f000_0000_0000,
        80'h0000_5000_3fff_4000_0001, 80'h0001_8000_0000_6000_0003,
        80'h0002_1000_4000_6800_0007, 80'h0003_6000_2000_6800_0007,
        80'h0000_1234_1234_2800_0006, 80'h0001_0000_2000_0800_0004,
        80'h0002_7fff_7fff_0000_0000, 80'h0003_0000_0000_0200_0008};
    logic [15:0] bad_cfg [4] = '{16'h1000, 16'h7000, 16'h0100, 16'h0f00};
    initial begin
        forever #50 pclk = ~pclk;
    end
    aix_result_words #(.NCH(4)) i_dut (.pclk(pclk), .presetn(presetn),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ch_sample(ch_sample),
        .ch_sample_valid(ch_sample_valid), .hw_error(hw_error),
        .running(running), .irq(irq));
    aix_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));
    task complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [5:0] idx,
        input logic [31:0] wd);
        logic ok;
        u_host.xfer(wr, idx, wd, rdat, err, ok);
        if (!ok) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0);
        `CHK(rdat, e)
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        xfer(1'b1, idx, d);
    endtask
    // Settled look at run state and interrupt away from the rising edge
    task automatic pchk(input logic [1:0] e);
        @(negedge pclk);
        `CHK({running, irq}, e)
        @(posedge pclk);
    endtask
    task automatic send(input int ch, input logic [15:0] s);
        ch_sample[16*ch +: 16] <= s;
        ch_sample_valid <= 4'h1 << ch;
        @(posedge pclk);
        ch_sample_valid <= 4'h0;
        @(posedge pclk);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rd(i[5:0], 32'h0);
        rd(6'h07, 32'h0);
        `CHK(err, 1'b1)
        wr(6'h00, 32'hffff);
        rd(6'h00, 32'h0);
        foreach (bad_cfg[i]) begin
            wr(6'h08, {16'h0, bad_cfg[i]});
            wr(6'h0c, 32'h1);
            rd(6'h0d, 32'h12);
            wr(6'h0c, 32'h0);
        end
        rd(6'h0e, 32'h1);
        pchk(2'b00);
        wr(6'h0f, 32'h3f);
        pchk(2'b01);
        wr(6'h0e, 32'h1);
        pchk(2'b00);
        wr(6'h08, 32'h0000);
        wr(6'h09, 32'h2000);
        wr(6'h0a, 32'h0300);
        wr(6'h0b, 32'h2300);
        wr(6'h0c, 32'h1);
        pchk(2'b10);
        foreach (vec[i]) begin
            send(int'(vec[i][65:64]), vec[i][63:48]);
            rd(vec[i][69:64], {16'h0, vec[i][47:32]});
            rd(6'h05, {16'h0, vec[i][31:16]});
            rd(6'h04, {16'h0, vec[i][15:0]});
        end
        rd(6'h0e, 32'h3c);
        pchk(2'b11);
        wr(6'h08, 32'h2000);
        send(0, 16'h1234);
        rd(6'h00, 32'h1234);
        wr(6'h0e, 32'h3f);
        pchk(2'b10);
        hw_error <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(6'h04, 32'hf);
        rd(6'h0e, 32'h2);
        pchk(2'b11);
        wr(6'h0c, 32'h0);
        // Flags clear one edge after running falls
        @(posedge pclk);
        rd(6'h05, 32'h0);
        pchk(2'b01);
        complete_run();
    end
endmodule
`default_nettype wire
